// ### shared/gafp_pkg.sv
package gafp_pkg;

    // ========================================
    // bus shape
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic awvalid;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [AXI_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_ADDR_W-1:0] araddr;
        logic rready;
    } gafp_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } gafp_axi_rsp_type;

    // ========================================
    // register offsets
    localparam logic [AXI_ADDR_W-1:0] OFS_DIR = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFS_OPEN_DRAIN = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFS_OUT = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFS_IN = 8'h0C;
    localparam logic [AXI_ADDR_W-1:0] OFS_ALT = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] OFS_CTRL = 8'h14;
    localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h18;

    // ========================================
    // alternate function select fields
    localparam int ALT_W = 9;
    localparam int ALT_SERIAL = 0;
    localparam int ALT_PARK = 1;
    localparam int ALT_INTERLOCK = 2;
    localparam int ALT_PATTERN = 3;
    localparam int ALT_PATTERN_POL = 4;
    localparam int ALT_LS_POWER = 5;
    localparam int ALT_GLASSES = 6;
    localparam int ALT_CAP_CHARGE = 7;
    localparam int ALT_LIGHT_MODE = 8;
    localparam logic [ALT_W-1:0] ALT_RESET = 9'h000;

    // control and status fields
    localparam int CTRL_W = 2;
    localparam int CTRL_LS_POWER = 0;
    localparam int CTRL_CAP_CHARGE = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam int STAT_W = 4;
    localparam int STAT_MASTER = 0;
    localparam int STAT_PARK = 1;
    localparam int STAT_FORCED = 2;
    localparam int STAT_ROLE_VALID = 3;

    // ========================================
    // pin map
    localparam int NUM_PINS = 11;
    localparam int PIN_SER_CLK = 1;
    localparam int PIN_SER_DOUT = 2;
    localparam int PIN_SER_SEL = 3;
    localparam int PIN_STRAP = 4;
    localparam int PIN_PATTERN = 6;
    localparam int PIN_INTERLOCK = 7;
    localparam int PIN_PARK = 8;
    localparam int PIN_LS = 9;
    localparam int PIN_CAP = 10;

    // ========================================
    // timing
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam int CLK_MHZ = 200;
    localparam int ILK_RELEASE_MS = 100;
    localparam int ILK_RELEASE_CYCLES = ILK_RELEASE_MS * 1000 * CLK_MHZ;
    localparam int ILK_CNT_W = 25;

endpackage

// ### verilog/gafp_sync.sv
module gafp_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = gafp_pkg::SYNC_STAGES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import gafp_pkg::*;

    logic [STAGES-1:0][WIDTH-1:0] stage_reg;

    // first stage feeds only the next stage
    always_ff @(posedge clk) begin
        if (srst) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= {stage_reg[STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = stage_reg[STAGES-1];

    a_sync_two_stage: assert property (
        @(posedge clk) disable iff (srst)
        (!$past(srst, 2) && !$past(srst)) |-> syncOut == $past(asyncIn, 2))
        else $error("synchroniser output is not input delayed two clocks");

endmodule

// ### verilog/gafp_port.sv
// Design decisions made here: the address map and the AXI4-Lite register port.
module gafp_port #(
    parameter int ILK_DELAY_CYCLES = gafp_pkg::ILK_RELEASE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire gafp_pkg::gafp_axi_req_type axiReq,
    output gafp_pkg::gafp_axi_rsp_type axiRsp,
    input wire logic [gafp_pkg::NUM_PINS-1:0] gpioIn,
    output logic [gafp_pkg::NUM_PINS-1:0] gpioOut,
    output logic [gafp_pkg::NUM_PINS-1:0] gpioOe,
    input wire logic ledDriverOnReq,
    input wire logic [2:0] ledSelectReq,
    output logic ledDriverOnOut,
    output logic [2:0] ledSelectOut,
    input wire logic leftEyeFrame,
    input wire logic patternSeqStart,
    input wire logic secondTriggerOutput,
    input wire logic serialPort1Select0N,
    input wire logic serialPort1Out,
    input wire logic serialPort1Sclk,
    output logic parkRequest,
    output logic roleMaster
);
    import gafp_pkg::*;

    // ========================================
    // registers
    logic [NUM_PINS-1:0] dir_reg;
    logic [NUM_PINS-1:0] openDrain_reg;
    logic [NUM_PINS-1:0] out_reg;
    logic [ALT_W-1:0] alt_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    gafp_axi_rsp_type rsp_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [AXI_ADDR_W-1:0] awAddr_reg;
    logic [AXI_DATA_W-1:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic [NUM_PINS-1:0] pinSync;
    logic [ILK_CNT_W-1:0] holdCnt_reg;
    logic [1:0] strapWait_reg;
    logic strapDone_reg;
    logic roleMaster_reg;
    logic parkRequest_reg;
    logic ledDriverOnOut_reg;
    logic [2:0] ledSelectOut_reg;
    logic [NUM_PINS-1:0] gpioOut_reg;
    logic [NUM_PINS-1:0] gpioOe_reg;

    logic [NUM_PINS-1:0] baseOut;
    logic [NUM_PINS-1:0] baseOe;
    logic [NUM_PINS-1:0] gpioOut_next;
    logic [NUM_PINS-1:0] gpioOe_next;
    logic [NUM_PINS-1:0] altMask;
    logic ledInterlockIn;
    logic hostProjectorOn;
    logic roleStrap;
    logic ilkForced;
    logic lightMaster;
    logic patternPulse;
    logic doWrite;
    logic [STAT_W-1:0] status;

    assign axiRsp = rsp_reg;
    assign gpioOut = gpioOut_reg;
    assign gpioOe = gpioOe_reg;
    assign ledDriverOnOut = ledDriverOnOut_reg;
    assign ledSelectOut = ledSelectOut_reg;
    assign parkRequest = parkRequest_reg;
    assign roleMaster = roleMaster_reg;

    // ========================================
    // pin input synchronisers
    gafp_sync #(
        .WIDTH(NUM_PINS),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .asyncIn(gpioIn),
        .syncOut(pinSync)
    );

    assign ledInterlockIn = pinSync[PIN_INTERLOCK];
    assign hostProjectorOn = pinSync[PIN_PARK];
    assign roleStrap = pinSync[PIN_STRAP];

    // ========================================
    // bus slave
    function automatic logic [AXI_DATA_W-1:0] mergeStrb(
        input logic [AXI_DATA_W-1:0] oldVal,
        input logic [AXI_DATA_W-1:0] newVal,
        input logic [3:0] strb
    );
        logic [AXI_DATA_W-1:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = newVal[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign doWrite = awHeld_reg && wHeld_reg && !rsp_reg.bvalid;

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_reg.awready <= 1'b1;
            rsp_reg.wready <= 1'b1;
            rsp_reg.bvalid <= 1'b0;
            rsp_reg.bresp <= RESP_OKAY;
            rsp_reg.arready <= 1'b1;
            rsp_reg.rvalid <= 1'b0;
            rsp_reg.rdata <= '0;
            rsp_reg.rresp <= RESP_OKAY;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else begin
            if (axiReq.awvalid && rsp_reg.awready) begin
                rsp_reg.awready <= 1'b0;
                awHeld_reg <= 1'b1;
                awAddr_reg <= axiReq.awaddr;
            end
            if (axiReq.wvalid && rsp_reg.wready) begin
                rsp_reg.wready <= 1'b0;
                wHeld_reg <= 1'b1;
                wData_reg <= axiReq.wdata;
                wStrb_reg <= axiReq.wstrb;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                rsp_reg.bvalid <= 1'b1;
                case (awAddr_reg)
                    OFS_DIR, OFS_OPEN_DRAIN, OFS_OUT, OFS_ALT,
                    OFS_CTRL, OFS_IN, OFS_STATUS: begin
                        rsp_reg.bresp <= RESP_OKAY;
                    end
                    default: begin
                        rsp_reg.bresp <= RESP_SLVERR;
                    end
                endcase
            end
            if (rsp_reg.bvalid && axiReq.bready) begin
                rsp_reg.bvalid <= 1'b0;
                rsp_reg.awready <= 1'b1;
                rsp_reg.wready <= 1'b1;
            end
            // read side kept in this process so the struct has one driver
            if (axiReq.arvalid && rsp_reg.arready) begin
                rsp_reg.arready <= 1'b0;
                rsp_reg.rvalid <= 1'b1;
                rsp_reg.rresp <= RESP_OKAY;
                case (axiReq.araddr)
                    OFS_DIR: rsp_reg.rdata <= 32'(dir_reg);
                    OFS_OPEN_DRAIN: rsp_reg.rdata <= 32'(openDrain_reg);
                    OFS_OUT: rsp_reg.rdata <= 32'(out_reg);
                    OFS_IN: rsp_reg.rdata <= 32'(pinSync);
                    OFS_ALT: rsp_reg.rdata <= 32'(alt_reg);
                    OFS_CTRL: rsp_reg.rdata <= 32'(ctrl_reg);
                    OFS_STATUS: rsp_reg.rdata <= 32'(status);
                    default: begin
                        rsp_reg.rdata <= '0;
                        rsp_reg.rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (rsp_reg.rvalid && axiReq.rready) begin
                rsp_reg.rvalid <= 1'b0;
                rsp_reg.arready <= 1'b1;
            end
        end
    end

    // read-only registers ignore writes but still answer okay
    always_ff @(posedge clk) begin
        if (srst) begin
            dir_reg <= '0;
            openDrain_reg <= '0;
            out_reg <= '0;
            alt_reg <= ALT_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (doWrite) begin
            case (awAddr_reg)
                OFS_DIR: begin
                    dir_reg <= NUM_PINS'(mergeStrb(32'(dir_reg), wData_reg,
                        wStrb_reg));
                end
                OFS_OPEN_DRAIN: begin
                    openDrain_reg <= NUM_PINS'(mergeStrb(32'(openDrain_reg),
                        wData_reg, wStrb_reg));
                end
                OFS_OUT: begin
                    out_reg <= NUM_PINS'(mergeStrb(32'(out_reg), wData_reg,
                        wStrb_reg));
                end
                OFS_ALT: begin
                    alt_reg <= ALT_W'(mergeStrb(32'(alt_reg), wData_reg,
                        wStrb_reg));
                end
                OFS_CTRL: begin
                    ctrl_reg <= CTRL_W'(mergeStrb(32'(ctrl_reg), wData_reg,
                        wStrb_reg));
                end
                default: begin
                end
            endcase
        end
    end

    assign status = {strapDone_reg, ilkForced, parkRequest_reg,
        roleMaster_reg};

    // ========================================
    // role strap, caught once after the synchroniser has settled
    always_ff @(posedge clk) begin
        if (srst) begin
            strapWait_reg <= '0;
            strapDone_reg <= 1'b0;
            roleMaster_reg <= 1'b0;
        end else if (!strapDone_reg) begin
            if (strapWait_reg == STRAP_SETTLE) begin
                strapDone_reg <= 1'b1;
                roleMaster_reg <= roleStrap;
            end else begin
                strapWait_reg <= strapWait_reg + 2'h1;
            end
        end
    end

    // ========================================
    // park request and LED interlock
    always_ff @(posedge clk) begin
        if (srst) begin
            parkRequest_reg <= 1'b0;
        end else begin
            // park only; powering the array down is the supply's job
            parkRequest_reg <= alt_reg[ALT_PARK] && !hostProjectorOn;
        end
    end

    // counter reloads while low, so every rise restarts the full delay
    always_ff @(posedge clk) begin
        if (srst) begin
            holdCnt_reg <= '0;
        end else if (!ledInterlockIn) begin
            holdCnt_reg <= ILK_CNT_W'(ILK_DELAY_CYCLES);
        end else if (holdCnt_reg != '0) begin
            holdCnt_reg <= holdCnt_reg - ILK_CNT_W'(1);
        end
    end

    assign ilkForced = alt_reg[ALT_INTERLOCK]
        && (!ledInterlockIn || holdCnt_reg != '0);

    always_ff @(posedge clk) begin
        if (srst) begin
            ledDriverOnOut_reg <= 1'b0;
            ledSelectOut_reg <= 3'h0;
        end else if (ilkForced) begin
            ledDriverOnOut_reg <= 1'b0;
            ledSelectOut_reg <= 3'h0;
        end else begin
            ledDriverOnOut_reg <= ledDriverOnReq;
            ledSelectOut_reg <= ledSelectReq;
        end
    end

    // ========================================
    // pin drivers
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        // open drain only pulls low; the board pull-up gives the high
        assign baseOe[i] = dir_reg[i]
            && (!openDrain_reg[i] || !out_reg[i]);
        assign baseOut[i] = out_reg[i] && !openDrain_reg[i];
    end

    assign lightMaster = roleMaster_reg && alt_reg[ALT_LIGHT_MODE];
    assign patternPulse = patternSeqStart && lightMaster;

    always_comb begin
        gpioOut_next = baseOut;
        gpioOe_next = baseOe;
        altMask = '0;
        if (alt_reg[ALT_SERIAL]) begin
            altMask[PIN_SER_SEL:PIN_SER_CLK] = 3'h7;
            gpioOe_next[PIN_SER_SEL:PIN_SER_CLK] = 3'h7;
            gpioOut_next[PIN_SER_CLK] = serialPort1Sclk;
            gpioOut_next[PIN_SER_DOUT] = serialPort1Out;
            gpioOut_next[PIN_SER_SEL] = serialPort1Select0N;
        end
        altMask[PIN_STRAP] = 1'b1;
        gpioOe_next[PIN_STRAP] = 1'b0;
        if (alt_reg[ALT_PATTERN]) begin
            altMask[PIN_PATTERN] = 1'b1;
            gpioOe_next[PIN_PATTERN] = 1'b1;
            gpioOut_next[PIN_PATTERN] = patternPulse
                ? alt_reg[ALT_PATTERN_POL]
                : !alt_reg[ALT_PATTERN_POL];
        end
        if (lightMaster) begin
            altMask[PIN_INTERLOCK] = 1'b1;
            gpioOe_next[PIN_INTERLOCK] = 1'b1;
            gpioOut_next[PIN_INTERLOCK] = secondTriggerOutput;
        end else if (alt_reg[ALT_INTERLOCK]) begin
            altMask[PIN_INTERLOCK] = 1'b1;
            gpioOe_next[PIN_INTERLOCK] = 1'b0;
        end
        if (alt_reg[ALT_PARK]) begin
            altMask[PIN_PARK] = 1'b1;
            gpioOe_next[PIN_PARK] = 1'b0;
        end
        if (alt_reg[ALT_LS_POWER]) begin
            altMask[PIN_LS] = 1'b1;
            gpioOe_next[PIN_LS] = 1'b1;
            gpioOut_next[PIN_LS] = ctrl_reg[CTRL_LS_POWER];
        end else if (alt_reg[ALT_GLASSES]) begin
            altMask[PIN_LS] = 1'b1;
            gpioOe_next[PIN_LS] = 1'b1;
            gpioOut_next[PIN_LS] = leftEyeFrame;
        end
        if (alt_reg[ALT_CAP_CHARGE]) begin
            altMask[PIN_CAP] = 1'b1;
            gpioOe_next[PIN_CAP] = 1'b1;
            gpioOut_next[PIN_CAP] = ctrl_reg[CTRL_CAP_CHARGE];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gpioOut_reg <= '0;
            gpioOe_reg <= '0;
        end else begin
            gpioOut_reg <= gpioOut_next;
            gpioOe_reg <= gpioOe_next;
        end
    end

    // ========================================
    // checks
    a_reset_all_inputs: assert property (
        @(posedge clk) disable iff (srst)
        $fell(srst) |-> (gpioOe == '0 && dir_reg == '0 && alt_reg == '0))
        else $error("pins not all inputs after reset");

    a_open_drain_low: assert property (
        @(posedge clk) disable iff (srst)
        (gpioOe & gpioOut & $past(openDrain_reg & ~altMask)) == '0)
        else $error("open drain pin drove high");

    a_park_no_power: assert property (
        @(posedge clk) disable iff (srst)
        (alt_reg[ALT_PARK] && !hostProjectorOn)
        |=> parkRequest && !gpioOe[PIN_PARK])
        else $error("park request not raised for low input");

    a_interlock_force: assert property (
        @(posedge clk) disable iff (srst)
        (alt_reg[ALT_INTERLOCK] && !ledInterlockIn)
        |=> !ledDriverOnOut && ledSelectOut == 3'h0)
        else $error("led outputs not forced off by interlock");

    a_interlock_hold: assert property (
        @(posedge clk) disable iff (srst)
        ($rose(ledInterlockIn) && alt_reg[ALT_INTERLOCK])
        |=> ##1 (!ledDriverOnOut && ledSelectOut == 3'h0)[*8])
        else $error("interlock released too early after rise");

    a_led_follow: assert property (
        @(posedge clk) disable iff (srst)
        !ilkForced |=> ledSelectOut == $past(ledSelectReq))
        else $error("led select not following sequencer");

    a_glasses_eye: assert property (
        @(posedge clk) disable iff (srst)
        (alt_reg[ALT_GLASSES] && !alt_reg[ALT_LS_POWER])
        |=> gpioOe[PIN_LS] && gpioOut[PIN_LS] == $past(leftEyeFrame))
        else $error("glasses pin not tracking eye");

    a_sensor_power: assert property (
        @(posedge clk) disable iff (srst)
        alt_reg[ALT_LS_POWER]
        |=> gpioOe[PIN_LS]
            && gpioOut[PIN_LS] == $past(ctrl_reg[CTRL_LS_POWER]))
        else $error("sensor power pin wrong");

    a_pattern_pulse: assert property (
        @(posedge clk) disable iff (srst)
        (alt_reg[ALT_PATTERN] && patternPulse ##1 !patternSeqStart
            && $stable(alt_reg))
        |=> gpioOut[PIN_PATTERN] == !alt_reg[ALT_PATTERN_POL]
            && $past(gpioOut[PIN_PATTERN]) == alt_reg[ALT_PATTERN_POL])
        else $error("pattern ready pulse shape wrong");

    a_trigger_pin: assert property (
        @(posedge clk) disable iff (srst)
        lightMaster |=> gpioOe[PIN_INTERLOCK]
            && gpioOut[PIN_INTERLOCK] == $past(secondTriggerOutput))
        else $error("second trigger pin not dedicated");

    a_role_capture: assert property (
        @(posedge clk) disable iff (srst)
        $rose(strapDone_reg) |-> roleMaster == $past(roleStrap))
        else $error("role not taken from strap");

    a_serial_pins: assert property (
        @(posedge clk) disable iff (srst)
        alt_reg[ALT_SERIAL] |=> gpioOe[PIN_SER_SEL]
            && gpioOut[PIN_SER_SEL] == $past(serialPort1Select0N))
        else $error("serial select pin not driven");

endmodule

// ### dv/gafp_far_model.sv
module gafp_far_model
    import gafp_pkg::*;
(
    input wire logic [gafp_pkg::NUM_PINS-1:0] gpioOut,
    input wire logic [gafp_pkg::NUM_PINS-1:0] gpioOe,
    input wire logic parkLvl,
    input wire logic ilkLvl,
    input wire logic strapLvl,
    output logic [gafp_pkg::NUM_PINS-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // wire resolution
    // board pull-ups: open drain highs and an idle serial select read 1
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pins[i] = gpioOe[i] ? gpioOut[i] : 1'h1;
        end
        // far side drives only while the pin is not an output
        if (!gpioOe[PIN_STRAP]) begin
            pins[PIN_STRAP] = strapLvl;
        end
        if (!gpioOe[PIN_INTERLOCK]) begin
            pins[PIN_INTERLOCK] = ilkLvl;
        end
        if (!gpioOe[PIN_PARK]) begin
            pins[PIN_PARK] = parkLvl;
        end
    end
endmodule

// ### dv/test_gafp_port.sv
module test_gafp_port;
    timeunit 1ns;
    timeprecision 1ps;
    import gafp_pkg::*;
    logic clk = 0;
    logic srst = 1;
    gafp_axi_req_type axiReq = '0;
    gafp_axi_rsp_type axiRsp;
    logic [NUM_PINS-1:0] gpioOut, gpioOe, pins;
    logic drvOn = 0, ledOn, leftEye = 0, patStart = 0, trig = 0;
    logic [2:0] sel = 0, ledSel, ser = 0;
    logic park, master, parkLvl = 1, ilkLvl = 1, strapLvl = 1;
    int fails = 0, n_tests = 0;
    logic [33:0] expQ[$];
    logic [1:0] expB[$];
    logic [31:0] r;
    always #2.5 clk = ~clk;
    gafp_port #(.ILK_DELAY_CYCLES(16)) dut (.clk(clk), .srst(srst),
        .axiReq(axiReq), .axiRsp(axiRsp), .gpioIn(pins),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .ledDriverOnReq(drvOn),
        .ledSelectReq(sel), .ledDriverOnOut(ledOn), .ledSelectOut(ledSel),
        .leftEyeFrame(leftEye), .patternSeqStart(patStart),
        .secondTriggerOutput(trig), .serialPort1Select0N(ser[2]),
        .serialPort1Out(ser[1]), .serialPort1Sclk(ser[0]),
        .parkRequest(park), .roleMaster(master));
    gafp_far_model far (.gpioOut(gpioOut), .gpioOe(gpioOe),
        .parkLvl(parkLvl), .ilkLvl(ilkLvl), .strapLvl(strapLvl),
        .pins(pins));
    // ========================================
    // reporting
    task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ========================================
    // bus master
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
        int n;
        expB.push_back(rs);
        @(posedge clk);
        axiReq.awvalid <= 1;
        axiReq.wvalid <= 1;
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hf;
        axiReq.bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (axiRsp.awready) axiReq.awvalid <= 0;
            if (axiRsp.wready) axiReq.wvalid <= 0;
            if (axiRsp.bvalid) break;
        end
        axiReq.bready <= 0;
        if (n == 50) begin
            fails++;
            tally_and_finish;
        end
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        expQ.push_back(e);
        @(posedge clk);
        axiReq.arvalid <= 1;
        axiReq.araddr <= a;
        axiReq.rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (axiRsp.arready) axiReq.arvalid <= 0;
            if (axiRsp.rvalid) break;
        end
        axiReq.rready <= 0;
        if (n == 50) begin
            fails++;
            tally_and_finish;
        end
    endtask
    // pre-edge values are seen here, as the design updates by nba
    always @(posedge clk) begin
        if (axiRsp.rvalid && axiReq.rready)
            chk("read", expQ.pop_front(), {axiRsp.rresp, axiRsp.rdata});
        if (axiRsp.bvalid && axiReq.bready)
            chk("bresp", expB.pop_front(), axiRsp.bresp);
    end
    // ========================================
    // scenarios
    initial begin
        void'($urandom(32'hce73));
        repeat (12) @(posedge clk);
        srst <= 0;
        tick(6);
        chk("oe", 0, gpioOe);
        chk("role", 1, master);
        rd(OFS_DIR, 0);
        rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0009});
        rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
        wr(8'h40, 32'h0000_0001, RESP_SLVERR);
        r = $urandom & 32'h0000_066f;
        wr(OFS_DIR, 32'h0000_066f, RESP_OKAY);
        wr(OFS_OUT, r, RESP_OKAY);
        tick(2);
        chk("oe", 11'h66f, gpioOe);
        chk("pins", r, pins & 11'h66f);
        wr(OFS_OPEN_DRAIN, 32'h0000_066f, RESP_OKAY);
        tick(2);
        chk("odoe", ~r & 11'h66f, gpioOe);
        chk("odpins", r, pins & 11'h66f);
        rd(OFS_IN, {RESP_OKAY, r | 32'h0000_0190});
        wr(OFS_OPEN_DRAIN, 0, RESP_OKAY);
        wr(OFS_OUT, 0, RESP_OKAY);
        wr(OFS_ALT, 32'h0000_0002, RESP_OKAY);
        @(posedge clk) parkLvl <= 0;
        tick(4);
        chk("park", 1, park);
        @(posedge clk) parkLvl <= 1;
        tick(4);
        chk("park", 0, park);
        @(posedge clk) drvOn <= 1;
        sel <= 3'($urandom | 1);
        wr(OFS_ALT, 32'h0000_0004, RESP_OKAY);
        tick(3);
        chk("led", {1'h1, sel}, {ledOn, ledSel});
        @(posedge clk) ilkLvl <= 0;
        tick(4);
        chk("led", 0, {ledOn, ledSel});
        @(posedge clk) ilkLvl <= 1;
        tick(12);
        chk("led", 0, {ledOn, ledSel});
        tick(12);
        chk("led", {1'h1, sel}, {ledOn, ledSel});
        wr(OFS_ALT, 32'h0000_0040, RESP_OKAY);
        for (int e = 1; e >= 0; e--) begin
            @(posedge clk) leftEye <= e[0];
            tick(2);
            chk("eye", e, pins[9]);
        end
        wr(OFS_ALT, 32'h0000_00a0, RESP_OKAY);
        for (int v = 1; v >= 0; v--) begin
            wr(OFS_CTRL, v * 3, RESP_OKAY);
            tick(2);
            chk("lspwr", v, pins[9]);
            chk("capchg", v, pins[10]);
        end
        wr(OFS_ALT, 32'h0000_0001, RESP_OKAY);
        @(posedge clk) ser <= 3'($urandom);
        tick(2);
        chk("serial", ser, pins[3:1]);
        for (int p = 0; p < 2; p++) begin
            wr(OFS_ALT, 32'h0000_0108 | (p << 4), RESP_OKAY);
            @(posedge clk) trig <= !p;
            tick(2);
            chk("trig", !p, pins[7]);
            chk("patidle", !p, pins[6]);
            @(posedge clk) patStart <= 1;
            @(posedge clk) patStart <= 0;
            #1;
            chk("patpulse", p, pins[6]);
            tick(1);
            chk("patidle", !p, pins[6]);
        end
        // second reset with the strap low selects the slave role
        @(posedge clk) strapLvl <= 0;
        srst <= 1;
        tick(3);
        @(posedge clk) srst <= 0;
        tick(6);
        chk("role", 0, master);
        chk("oe", 0, gpioOe);
        tally_and_finish;
    end
endmodule
